// *** include/label_gen_defs.vh ***
/*
 * Constants for the request label generator: register offsets, field
 * positions, reset values, request kinds and version codes.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
// Notes on behaviour
// RQ1 - Unprivileged loads/stores labelled like ordinary ones
// RQ2 - Nested sysreg memory accesses use hypervisor data labels
// RQ3 - Profiling buffer writes use owner tier data labels
// RQ4 - Probe walks labelled as data loads from tier
// RQ5 - Probe's named stage and level are ignored
// RQ6 - Same labels secure or not; flag differs
// RQ7 - Secure partition flag 0, non-secure flag 1
// RQ8 - Secure state flag 0 from version 1.0
// RQ9 - Tier n takes labels from tier n register
// RQ10 - Virtual mapping path identical in secure state
// RQ11 - Label flag separate from address space flag
// RQ12 - Never flag 1 with secure address space
// RQ13 - Version 1.0 has no default/override controls
// RQ14 - Default select 0: per-tier labels, normal flags
// RQ15 - Default select 1: secure gets default labels, flag 0
// RQ16 - Version 0.1 override: secure flag 1, tier labels
// RQ17 - Version 0.1 both set: flag 1, default labels
// RQ18 - Override without secure ids reads one, ignores writes
// RQ19 - Otherwise override bit is ordinary read-write
// RQ20 - Software probes override by writing zero, reading back
// RQ21 - Fetches use instruction pair, data uses data pair
// RQ22 - Register chosen by tier, guest lock redirects application
// RQ23 - Default labels come from constant inputs
`ifndef LABEL_GEN_DEFS_VH
`define LABEL_GEN_DEFS_VH

// Register byte offsets
`define OFS_APP_REG 12'h000
`define OFS_GUEST_REG 12'h004
`define OFS_HYP_REG 12'h008
`define OFS_MON_REG 12'h00c
`define OFS_CTRL_REG 12'h010
`define OFS_ID_REG 12'h014
`define OFS_ERR_REG 12'h018

// Per-tier label register layout
`define PID_W 8
`define MG_W 4
`define F_DPID 7:0
`define F_IPID 15:8
`define F_DMG 19:16
`define F_IMG 23:20
`define LBL_MASK 32'h00ffffff
`define LBL_RESET 32'h00000000
// Monitor tier register extra controls
`define B_SDEF 24
`define B_OVR 25
// Control register
`define B_GLOCK 0
`define B_HOSTHYP 1
`define CTRL_MASK 32'h00000003
// Identification register
`define F_ID_VER 1:0
`define B_ID_OVRCAP 2
`define B_ID_SECPID 3
// Error register
`define B_ERR_ILLEGAL 0

// Version codes
`define VER_V01 2'h0
`define VER_V10 2'h1
`define VER_V11 2'h2

// Tiers
`define TIER_APP 2'h0
`define TIER_GUEST 2'h1
`define TIER_HYP 2'h2
`define TIER_MON 2'h3

// Request kinds
`define KIND_NORMAL 3'h0
`define KIND_UNPRIV 3'h1
`define KIND_NESTED 3'h2
`define KIND_PROFILE 3'h3
`define KIND_PROBE 3'h4

`endif

// *** hw/req_label_gen.v ***
/*
 * Request label generator: attaches partition id, monitor group and
 * secure-space flag to each outgoing memory-system request, with APB
 * access to the per-tier label registers and the secure controls.
 * Assumes requests and APB are synchronous to pclk; the memory system
 * accepts one labelled request per cycle without back-pressure.
 */
`include "label_gen_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module req_label_gen #(
   parameter [1:0] VERSION = `VER_V11,
   parameter OVERRIDE_CAP = 1'b1,
   parameter SECURE_PID_IMPL = 1'b1
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Implementation defaults for secure default select
   input wire [7:0] default_partition_id,
   input wire [3:0] default_monitor_group,
   // Request from the core
   input wire req_valid,
   input wire [2:0] req_kind,
   input wire [1:0] req_tier,
   input wire req_secure,
   input wire req_instr,
   input wire req_address_space_flag,
   input wire [1:0] prof_owner_tier,
   input wire prof_owner_secure,
   // Labelled request to the memory system
   output reg lbl_valid,
   output reg [7:0] partition_id,
   output reg [3:0] monitor_group,
   output reg label_secure_space_flag,
   output reg address_space_flag,
   output reg lbl_dropped
);

   // ****************************************************************
   // Register file
   // ****************************************************************
   reg [31:0] app_q;
   reg [31:0] guest_q;
   reg [31:0] hyp_q;
   reg [31:0] mon_q;
   reg [31:0] ctrl_q;
   reg sdef_q;
   reg ovr_q;
   reg err_q;

   wire has_controls = (VERSION != `VER_V10);
   // Override exists only where advertised, and never in 1.0
   wire ovr_rw = OVERRIDE_CAP && SECURE_PID_IMPL && has_controls;
   wire ovr_rao = OVERRIDE_CAP && !SECURE_PID_IMPL && has_controls;
   // Effective override seen by the flag logic and by reads
   wire ovr_eff = ovr_rao ? 1'b1 : (ovr_rw ? ovr_q : 1'b0); // RQ18 RQ19
   wire sdef_eff = has_controls ? sdef_q : 1'b0; // RQ13

   wire setup = psel & ~penable;
   wire wr_done = psel & penable & pwrite & pready;

   function map_hit;
      input [11:0] a;
      begin
         if (a == `OFS_APP_REG) map_hit = 1'b1;
         else if (a == `OFS_GUEST_REG) map_hit = 1'b1;
         else if (a == `OFS_HYP_REG) map_hit = 1'b1;
         else if (a == `OFS_MON_REG) map_hit = 1'b1;
         else if (a == `OFS_CTRL_REG) map_hit = 1'b1;
         else if (a == `OFS_ID_REG) map_hit = 1'b1;
         else if (a == `OFS_ERR_REG) map_hit = 1'b1;
         else map_hit = 1'b0;
      end
   endfunction

   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h00000000;
      if (paddr == `OFS_APP_REG) begin
         rd_d = app_q;
      end else if (paddr == `OFS_GUEST_REG) begin
         rd_d = guest_q;
      end else if (paddr == `OFS_HYP_REG) begin
         rd_d = hyp_q;
      end else if (paddr == `OFS_MON_REG) begin
         rd_d = mon_q;
         rd_d[`B_SDEF] = sdef_eff;
         rd_d[`B_OVR] = ovr_eff; // RQ18
      end else if (paddr == `OFS_CTRL_REG) begin
         rd_d = ctrl_q;
      end else if (paddr == `OFS_ID_REG) begin
         rd_d[`F_ID_VER] = VERSION;
         rd_d[`B_ID_OVRCAP] = OVERRIDE_CAP;
         rd_d[`B_ID_SECPID] = SECURE_PID_IMPL;
      end else if (paddr == `OFS_ERR_REG) begin
         rd_d[`B_ERR_ILLEGAL] = err_q;
      end
   end

   // Zero-wait access: ready rises for the access phase only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~map_hit(paddr);
         if (setup && !pwrite) begin
            prdata <= rd_d;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         app_q <= `LBL_RESET;
         guest_q <= `LBL_RESET;
         hyp_q <= `LBL_RESET;
         mon_q <= `LBL_RESET;
         ctrl_q <= 32'h00000000;
         sdef_q <= 1'b0;
         ovr_q <= 1'b0;
      end else if (wr_done) begin
         if (paddr == `OFS_APP_REG) begin
            app_q <= pwdata & `LBL_MASK;
         end else if (paddr == `OFS_GUEST_REG) begin
            guest_q <= pwdata & `LBL_MASK;
         end else if (paddr == `OFS_HYP_REG) begin
            hyp_q <= pwdata & `LBL_MASK;
         end else if (paddr == `OFS_MON_REG) begin
            mon_q <= pwdata & `LBL_MASK;
            // Controls are write-ignored where not implemented
            sdef_q <= has_controls & pwdata[`B_SDEF]; // RQ13
            ovr_q <= ovr_rw & pwdata[`B_OVR]; // RQ19 RQ20
         end else if (paddr == `OFS_CTRL_REG) begin
            ctrl_q <= pwdata & `CTRL_MASK;
         end
      end
   end

   // ****************************************************************
   // Label source selection
   // ****************************************************************
   function [31:0] tier_reg;
      input [1:0] tier;
      input lock;
      input [31:0] a;
      input [31:0] g;
      input [31:0] h;
      input [31:0] m;
      begin
         case (tier)
            `TIER_APP: tier_reg = lock ? g : a; // RQ22
            `TIER_GUEST: tier_reg = g;
            `TIER_HYP: tier_reg = h;
            default: tier_reg = m;
         endcase
      end
   endfunction

   // Unprivileged requests keep the executing tier and its instr/data
   // choice; probe requests use that tier's data path. The probe's own
   // stage and level never arrive here, so they cannot steer the label.
   reg [1:0] eff_tier;
   reg eff_secure;
   reg eff_instr;
   reg force_hyp;
   always @* begin
      eff_tier = req_tier; // RQ9 RQ1
      eff_secure = req_secure;
      eff_instr = req_instr; // RQ21
      force_hyp = 1'b0;
      case (req_kind)
         `KIND_NESTED: begin
            force_hyp = 1'b1; // RQ2
            eff_instr = 1'b0;
         end
         `KIND_PROFILE: begin
            eff_tier = prof_owner_tier; // RQ3
            eff_secure = prof_owner_secure;
            eff_instr = 1'b0;
         end
         `KIND_PROBE: begin
            eff_instr = 1'b0; // RQ4 RQ5
         end
         default: begin
            eff_instr = req_instr; // RQ1
         end
      endcase
   end

   wire [31:0] src = force_hyp ? hyp_q
      : tier_reg(eff_tier, ctrl_q[`B_GLOCK], app_q, guest_q, hyp_q, mon_q); // RQ22
   // Secure and non-secure share this path; only the flag differs
   wire [7:0] tier_pid = eff_instr ? src[`F_IPID] : src[`F_DPID]; // RQ21 RQ6 RQ10
   wire [3:0] tier_mg = eff_instr ? src[`F_IMG] : src[`F_DMG]; // RQ21

   // ****************************************************************
   // Secure-space flag
   // ****************************************************************
   reg flag_d;
   reg use_default;
   always @* begin
      flag_d = 1'b1; // RQ7 RQ14
      use_default = 1'b0;
      if (eff_secure) begin
         flag_d = 1'b0; // RQ7 RQ8
         use_default = sdef_eff; // RQ15 RQ17
         if (VERSION == `VER_V01) begin
            flag_d = ovr_eff; // RQ16 RQ17
         end
      end
   end

   // Label flag travels beside, never merged with, the address flag
   wire illegal = flag_d & ~req_address_space_flag; // RQ11 RQ12

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lbl_valid <= 1'b0;
         partition_id <= 8'h00;
         monitor_group <= 4'h0;
         label_secure_space_flag <= 1'b0;
         address_space_flag <= 1'b0;
         lbl_dropped <= 1'b0;
      end else begin
         lbl_valid <= req_valid & ~illegal; // RQ12
         lbl_dropped <= req_valid & illegal;
         if (req_valid) begin
            partition_id <= use_default ? default_partition_id : tier_pid; // RQ23
            monitor_group <= use_default ? default_monitor_group : tier_mg; // RQ23
            label_secure_space_flag <= flag_d; // RQ11
            address_space_flag <= req_address_space_flag;
         end
      end
   end

   // Sticky illegal-combination flag, write one to clear; set wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (req_valid && illegal) begin
         err_q <= 1'b1; // RQ12
      end else if (wr_done && paddr == `OFS_ERR_REG && pwdata[`B_ERR_ILLEGAL]) begin
         err_q <= 1'b0;
      end
   end

endmodule // req_label_gen

`default_nettype wire

// *** tb/label_gen_monitor.sv ***
/* Assertions on request answers and APB timing of req_label_gen.
   Bound to the design top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Checker
// ****************
module label_gen_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Request and label
   input wire logic req_valid,
   input wire logic [2:0] req_kind,
   input wire logic req_secure,
   input wire logic req_address_space_flag,
   input wire logic lbl_valid,
   input wire logic lbl_dropped,
   input wire logic label_secure_space_flag,
   input wire logic address_space_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("ready missing");
   apb_only_a: assert property (pready |-> $past(psel && !penable))
      else $error("stray ready");
   answer_once_a: assert property (req_valid |=> lbl_valid != lbl_dropped)
      else $error("no single answer");
   sec_flag_a: assert property (req_valid && req_secure && req_kind != 3'h3 |=>
      !label_secure_space_flag) else $error("secure flag high");
   ns_flag_a: assert property (req_valid && !req_secure && req_kind != 3'h3 |=>
      label_secure_space_flag) else $error("non-secure flag low");
   addr_pass_a: assert property (req_valid |=>
      address_space_flag == $past(req_address_space_flag)) else $error("address flag");
   legal_combo_a: assert property (lbl_valid |->
      !(label_secure_space_flag && !address_space_flag)) else $error("illegal issued");
   drop_cause_a: assert property (lbl_dropped |->
      label_secure_space_flag && !address_space_flag) else $error("needless drop");
endmodule // label_gen_monitor
bind req_label_gen label_gen_monitor u_label_gen_monitor (.pclk, .presetn, .psel, .penable,
   .pready, .req_valid, .req_kind, .req_secure, .req_address_space_flag, .lbl_valid,
   .lbl_dropped, .label_secure_space_flag, .address_space_flag);
`default_nettype wire

// *** tb/mem_sink.sv ***
/* Memory-side consumer: keeps the label of each accepted request.
   Assumes labels are valid in the cycle of lbl_valid. */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Sink
// ****************
module mem_sink (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Labelled request
   input wire logic lbl_valid,
   input wire logic [7:0] partition_id,
   input wire logic [3:0] monitor_group,
   input wire logic label_secure_space_flag,
   // Last label consumed
   output logic [12:0] seen_q
);
   // Never stalls: the generator has no back-pressure to honour
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q <= 13'h0000;
      end else if (lbl_valid) begin
         seen_q <= {label_secure_space_flag, monitor_group, partition_id};
      end
   end
endmodule // mem_sink
`default_nettype wire

// *** tb/req_label_gen_tb.sv ***
/* Self-checking bench for req_label_gen, version 1.1 with override bit.
   Assumes the sink holds the last label one cycle after lbl_valid. */
`timescale 1ns/1ps
`default_nettype none
`include "label_gen_defs.vh"
// ****************
// Bench
// ****************
module req_label_gen_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, drop, vld;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic req_valid, req_secure, req_instr, req_address_space_flag, prof_owner_secure;
   logic [2:0] req_kind;
   logic [1:0] req_tier, prof_owner_tier;
   logic lbl_valid, lbl_dropped, label_secure_space_flag, address_space_flag;
   logic [7:0] partition_id;
   logic [3:0] monitor_group;
   logic [12:0] seen_q;
   logic [7:0] default_partition_id = 8'h5a;
   logic [3:0] default_monitor_group = 4'h6;
   int err_total = 0;
   int samples_checked = 0;
   typedef struct packed {
      logic [2:0] k;
      logic [1:0] t, pt, et;
      logic s, i, ps, ei, ef;
   } row_t;
   // kind, tier, owner tier, expected tier, secure, instr, owner secure, exp instr, exp flag
   row_t rows [0:9] = '{'{0,0,0,0,0,1,0,1,1},
      '{0,1,0,1,1,0,0,0,0},
      '{1,1,0,1,0,0,0,0,1},
      '{2,1,0,2,0,1,0,0,1},
      '{3,0,2,2,0,0,0,0,1},
      '{3,3,1,1,1,0,1,0,0},
      '{4,3,0,3,1,1,0,0,0},
      '{0,2,0,2,0,0,0,0,1},
      '{0,3,0,3,1,1,0,1,0},
      '{0,0,0,1,0,0,0,0,1}};
   req_label_gen u_req_label_gen (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .default_partition_id, .default_monitor_group, .req_valid,
      .req_kind, .req_tier, .req_secure, .req_instr, .req_address_space_flag,
      .prof_owner_tier, .prof_owner_secure, .lbl_valid, .partition_id, .monitor_group,
      .label_secure_space_flag, .address_space_flag, .lbl_dropped);
   mem_sink u_mem_sink (.pclk, .presetn, .lbl_valid, .partition_id, .monitor_group,
      .label_secure_space_flag, .seen_q);
   function automatic logic [31:0] tw(input logic [1:0] t);
      return {8'h00, 2'h2, t, 2'h1, t, 6'h20, t, 6'h10, t};
   endfunction
   function automatic logic [12:0] lbl(input row_t r);
      logic [31:0] w;
      w = tw(r.et);
      return {r.ef, r.ei ? {w[23:20], w[15:8]} : {w[19:16], w[7:0]}};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   // Holds the request until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, 32'(pready));
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Drives one request and compares what the sink consumed
   task automatic lab(input row_t r, input logic [12:0] e);
      @(posedge pclk);
      {req_valid, req_kind, req_tier, req_secure} <= {1'b1, r.k, r.t, r.s};
      {req_instr, prof_owner_tier, prof_owner_secure} <= {r.i, r.pt, r.ps};
      @(posedge pclk);
      req_valid <= 1'b0;
      @(posedge pclk);
      drop = lbl_dropped;
      vld = lbl_valid;
      @(posedge pclk);
      chk("label", 32'(e), 32'(seen_q));
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {req_valid, req_kind, req_tier, req_secure, req_instr} = '0;
      {prof_owner_tier, prof_owner_secure, req_address_space_flag} = 3'h1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_MON_REG, 32'h0);
      chk("reset value", 32'h0, rd);
      for (int t = 0; t < 4; t++) begin
         apb(1'b1, 12'(t * 4), tw(2'(t)));
         apb(1'b0, 12'(t * 4), 32'h0);
         chk("tier reg", tw(2'(t)), rd);
      end
      for (int j = 0; j < 9; j++) begin
         lab(rows[j], lbl(rows[j]));
         chk("dropped", 32'h0, 32'(drop));
         chk("valid", 32'h1, 32'(vld));
      end
      $display("label table done");
      apb(1'b1, `OFS_CTRL_REG, 32'h1);
      lab(rows[9], lbl(rows[9]));
      apb(1'b1, `OFS_CTRL_REG, 32'h0);
      apb(1'b1, `OFS_MON_REG, tw(2'h3) | 32'h01000000);
      lab(rows[1], 13'h065a);
      lab(rows[2], lbl(rows[2]));
      apb(1'b1, `OFS_MON_REG, tw(2'h3) | 32'h02000000);
      apb(1'b0, `OFS_MON_REG, 32'h0);
      chk("override set", tw(2'h3) | 32'h02000000, rd);
      lab(rows[1], lbl(rows[1]));
      apb(1'b1, `OFS_MON_REG, tw(2'h3));
      apb(1'b0, `OFS_MON_REG, 32'h0);
      chk("override clear", tw(2'h3), rd);
      $display("secure controls done");
      @(posedge pclk) req_address_space_flag <= 1'b0;
      lab(rows[2], lbl(rows[1]));
      chk("drop", 32'h1, 32'(drop));
      chk("valid", 32'h0, 32'(vld));
      apb(1'b0, `OFS_ERR_REG, 32'h0);
      chk("error bit", 32'h1, rd);
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped", 32'h1, 32'(perr));
      $display("error cases done");
      // Reset in mid-run clears registers and the sticky error bit
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      chk("reset valid", 32'h0, 32'(lbl_valid));
      apb(1'b0, `OFS_APP_REG, 32'h0);
      chk("reset app", 32'h0, rd);
      apb(1'b0, `OFS_ERR_REG, 32'h0);
      chk("reset error", 32'h0, rd);
      $display("mid-run reset done");
      tally_and_finish();
   end
endmodule // req_label_gen_tb
`default_nettype wire
